// ---- ebt_pkg.sv ----
// Constants shared by the external bus cycle timing block
package ebt_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SPACE0_CFG   = 8'h00;
  localparam logic [7:0] OFF_SPACE1_CFG   = 8'h04;
  localparam logic [7:0] OFF_SPACE2_CFG   = 8'h08;
  localparam logic [7:0] OFF_SPACE3_CFG   = 8'h0C;
  localparam logic [7:0] OFF_CLOCK_CTRL   = 8'h10;
  localparam logic [7:0] OFF_STATUS       = 8'h14;

  // ----------------------------------------------------------------
  // Space timing register fields
  // ----------------------------------------------------------------
  localparam int POS_WRITE_WIDTH  = 0;
  localparam int POS_WRITE_SETUP  = 2;
  localparam int POS_READ_WIDTH   = 4;
  localparam int POS_READ_SETUP   = 6;
  localparam int POS_MULTIPLIER   = 8;
  localparam int POS_FORMAT       = 10;
  localparam int CFG_BITS         = 11;
  localparam logic [10:0] RST_SPACE_CFG = 11'h7FF;

  // ----------------------------------------------------------------
  // Clock control register fields
  // ----------------------------------------------------------------
  localparam int POS_BASE_DIV     = 0;
  localparam int POS_PERIPH_DIV   = 2;
  localparam int CLK_BITS         = 4;
  localparam logic [3:0] RST_CLOCK_CTRL = 4'h5;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int POS_BUSY         = 0;
  localparam int POS_LENGTH       = 8;

  // ----------------------------------------------------------------
  // Timing widths, in half base cycles
  // ----------------------------------------------------------------
  localparam int HALF_BITS        = 7;
  localparam logic [6:0] HALF_ONE = 7'h01;
  localparam logic [6:0] HALF_TWO = 7'h02;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETUP  = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_PAD    = 4'b1000
  } ebt_state_e;

endpackage

// ---- ebt_timing_calc.sv ----
// Per-access timing figures in half base cycles
`timescale 1ns/1ps
module ebt_timing_calc (
  input  wire logic [10:0] cfg,
  input  wire logic        is_write,
  input  wire logic [1:0]  periph_div,
  output logic      [6:0]  setup_h,
  output logic      [6:0]  width_h,
  output logic      [6:0]  idle_h
);

  logic [2:0] mpy;
  logic [2:0] su_cnt;
  logic [2:0] wd_cnt;
  logic [6:0] su_prod;
  logic [6:0] wd_prod;
  logic [6:0] len_h;
  logic [6:0] period_h;
  logic [6:0] rem_h;
  logic       mux_fmt;

  always_comb begin
    mux_fmt = cfg[ebt_pkg::POS_FORMAT];
    mpy = {1'b0, cfg[ebt_pkg::POS_MULTIPLIER +: 2]} + 3'h1;
    if (is_write) begin
      su_cnt = {1'b0, cfg[ebt_pkg::POS_WRITE_SETUP +: 2]};
      wd_cnt = {1'b0, cfg[ebt_pkg::POS_WRITE_WIDTH +: 2]} + 3'h1;
    end else begin
      su_cnt = {1'b0, cfg[ebt_pkg::POS_READ_SETUP +: 2]};
      wd_cnt = {1'b0, cfg[ebt_pkg::POS_READ_WIDTH +: 2]} + 3'h1;
    end
    // Products reach 16, so they are formed five bits wide
    su_prod = {1'b0, 5'(su_cnt) * 5'(mpy), 1'b0};
    wd_prod = {1'b0, 5'(wd_cnt) * 5'(mpy), 1'b0};
    if (!is_write && !mux_fmt) begin
      setup_h = su_prod + ebt_pkg::HALF_ONE;
      width_h = wd_prod + ebt_pkg::HALF_ONE;
    end else begin
      setup_h = su_prod + ebt_pkg::HALF_TWO;
      width_h = wd_prod - ebt_pkg::HALF_ONE;
    end
    // Pad to whole peripheral clocks
    len_h    = setup_h + width_h;
    period_h = 7'({periph_div, 1'b0}) + ebt_pkg::HALF_TWO;
    rem_h    = len_h % period_h;
    idle_h   = (rem_h == 7'h00) ? 7'h00 : period_h - rem_h;
  end

endmodule

// ---- ebt_bus_timing.sv ----
// External bus cycle timing generator with APB register access
`timescale 1ns/1ps
module ebt_bus_timing #(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input  wire logic          CLOCK,
  input  wire logic          NRST,
  // APB slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // Bus cycle requests
  input  wire logic          REQ_VALID,
  input  wire logic          REQ_WRITE,
  input  wire logic          REQ_INTERNAL,
  input  wire logic [1:0]    REQ_SPACE,
  input  wire logic [AW-1:0] REQ_ADDR,
  input  wire logic [DW-1:0] REQ_WDATA,
  output logic               REQ_READY,
  output logic               REQ_DONE,
  output logic      [DW-1:0] REQ_RDATA,
  // External bus pins
  output logic      [AW-1:0] ADDR_OUT,
  output logic      [3:0]    CS_N,
  output logic               RD_N,
  output logic               WR_N,
  output logic               ALE,
  input  wire logic [DW-1:0] DATA_IN,
  output logic      [DW-1:0] DATA_OUT,
  output logic               DATA_OE
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (AW < 8 || AW > 32) begin : g_aw_chk
    $error("AW must be 8 to 32");
  end
  if (DW < 8 || DW > 32 || DW > AW) begin : g_dw_chk
    $error("DW must be 8 to 32 and not above AW");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [10:0]          space_cfg_r [4];
  logic [3:0]           clk_ctrl_r;
  logic [31:0]          prdata_r;
  logic [2:0]           div_cnt_r;
  logic [2:0]           div_max;
  logic                 half_tick;
  ebt_pkg::ebt_state_e  state_r;
  logic [6:0]           cnt_r;
  logic [6:0]           width_r;
  logic [6:0]           idle_r;
  logic [6:0]           len_r;
  logic                 write_r;
  logic                 internal_r;
  logic                 mux_r;
  logic [1:0]           space_r;
  logic [AW-1:0]        addr_r;
  logic [DW-1:0]        wdata_r;
  logic [DW-1:0]        rdata_r;
  logic                 done_r;
  logic                 ale_r;
  logic                 strobe_r;
  logic [6:0]           calc_setup;
  logic [6:0]           calc_width;
  logic [6:0]           calc_idle;
  logic                 apb_setup;
  logic                 apb_wr;
  logic                 addr_ok;
  logic                 finish;
  logic                 start;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (PADDR)
      ebt_pkg::OFF_SPACE0_CFG,
      ebt_pkg::OFF_SPACE1_CFG,
      ebt_pkg::OFF_SPACE2_CFG,
      ebt_pkg::OFF_SPACE3_CFG,
      ebt_pkg::OFF_CLOCK_CTRL,
      ebt_pkg::OFF_STATUS:     addr_ok = 1'b1;
      default:                 addr_ok = 1'b0;
    endcase
  end

  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE & addr_ok;
  // Zero-wait slave; read data is staged in the setup cycle
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL & PENABLE & ~addr_ok;
  assign PRDATA    = prdata_r;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Writes may land mid-cycle; the running cycle keeps its snapshot
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      for (int i = 0; i < 4; i++) begin
        space_cfg_r[i] <= ebt_pkg::RST_SPACE_CFG;
      end
    end else if (apb_wr && PADDR[7:4] == 4'h0) begin
      space_cfg_r[PADDR[3:2]] <= PWDATA[ebt_pkg::CFG_BITS-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      clk_ctrl_r <= ebt_pkg::RST_CLOCK_CTRL;
    end else if (apb_wr && PADDR == ebt_pkg::OFF_CLOCK_CTRL) begin
      clk_ctrl_r <= PWDATA[ebt_pkg::CLK_BITS-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_r <= 32'h0000_0000;
      unique case (PADDR)
        ebt_pkg::OFF_SPACE0_CFG,
        ebt_pkg::OFF_SPACE1_CFG,
        ebt_pkg::OFF_SPACE2_CFG,
        ebt_pkg::OFF_SPACE3_CFG: begin
          prdata_r[ebt_pkg::CFG_BITS-1:0] <= space_cfg_r[PADDR[3:2]];
        end
        ebt_pkg::OFF_CLOCK_CTRL: begin
          prdata_r[ebt_pkg::CLK_BITS-1:0] <= clk_ctrl_r;
        end
        ebt_pkg::OFF_STATUS: begin
          prdata_r[ebt_pkg::POS_BUSY] <= (state_r != ebt_pkg::ST_IDLE);
          prdata_r[ebt_pkg::POS_LENGTH +: 7] <= len_r;
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Half base clock enable
  // ----------------------------------------------------------------
  // Code n gives one half base period every 2**n clocks
  always_comb begin
    unique case (clk_ctrl_r[ebt_pkg::POS_BASE_DIV +: 2])
      2'h0:    div_max = 3'h0;
      2'h1:    div_max = 3'h1;
      2'h2:    div_max = 3'h3;
      default: div_max = 3'h7;
    endcase
  end

  assign half_tick = (div_cnt_r >= div_max);

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      div_cnt_r <= 3'h0;
    end else if (half_tick) begin
      div_cnt_r <= 3'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Timing of the requested access
  // ----------------------------------------------------------------
  ebt_timing_calc u_calc (
    .cfg        (space_cfg_r[REQ_SPACE]),
    .is_write   (REQ_WRITE),
    .periph_div (clk_ctrl_r[ebt_pkg::POS_PERIPH_DIV +: 2]),
    .setup_h    (calc_setup),
    .width_h    (calc_width),
    .idle_h     (calc_idle)
  );

  // Back-to-back cycles chain on the closing half tick, no gap
  always_comb begin
    finish = 1'b0;
    if (half_tick && cnt_r == ebt_pkg::HALF_ONE) begin
      finish = (state_r == ebt_pkg::ST_PAD) ||
               (state_r == ebt_pkg::ST_STROBE && idle_r == 7'h00);
    end
  end

  assign REQ_READY = half_tick &&
                     (state_r == ebt_pkg::ST_IDLE || finish);
  assign start     = REQ_READY & REQ_VALID;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state_r <= ebt_pkg::ST_IDLE;
      cnt_r   <= 7'h00;
    end else if (start) begin
      state_r <= ebt_pkg::ST_SETUP;
      cnt_r   <= calc_setup;
    end else if (finish) begin
      state_r <= ebt_pkg::ST_IDLE;
      cnt_r   <= 7'h00;
    end else if (half_tick) begin
      unique case (state_r)
        ebt_pkg::ST_IDLE: begin
          cnt_r <= 7'h00;
        end
        ebt_pkg::ST_SETUP: begin
          if (cnt_r == ebt_pkg::HALF_ONE) begin
            state_r <= ebt_pkg::ST_STROBE;
            cnt_r   <= width_r;
          end else begin
            cnt_r <= cnt_r - 7'h01;
          end
        end
        ebt_pkg::ST_STROBE: begin
          if (cnt_r == ebt_pkg::HALF_ONE) begin
            state_r <= ebt_pkg::ST_PAD;
            cnt_r   <= idle_r;
          end else begin
            cnt_r <= cnt_r - 7'h01;
          end
        end
        ebt_pkg::ST_PAD: begin
          cnt_r <= cnt_r - 7'h01;
        end
        default: begin
          state_r <= ebt_pkg::ST_IDLE;
          cnt_r   <= 7'h00;
        end
      endcase
    end
  end

  // Snapshot held for the whole cycle
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      width_r    <= 7'h00;
      idle_r     <= 7'h00;
      len_r      <= 7'h00;
      write_r    <= 1'b0;
      internal_r <= 1'b0;
      mux_r      <= 1'b0;
      space_r    <= 2'h0;
      addr_r     <= '0;
      wdata_r    <= '0;
    end else if (start) begin
      width_r    <= calc_width;
      idle_r     <= calc_idle;
      len_r      <= calc_setup + calc_width + calc_idle;
      write_r    <= REQ_WRITE;
      internal_r <= REQ_INTERNAL;
      mux_r      <= space_cfg_r[REQ_SPACE][ebt_pkg::POS_FORMAT];
      space_r    <= REQ_SPACE;
      addr_r     <= REQ_ADDR;
      wdata_r    <= REQ_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  // Latch strobe: high from start when setup exceeds one half, low one half before the strobe
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ale_r <= 1'b0;
    end else if (start) begin
      ale_r <= (calc_setup > ebt_pkg::HALF_ONE);
    end else if (half_tick && state_r == ebt_pkg::ST_SETUP &&
                 cnt_r == ebt_pkg::HALF_TWO) begin
      ale_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      strobe_r <= 1'b0;
    end else if (half_tick && cnt_r == ebt_pkg::HALF_ONE) begin
      strobe_r <= (state_r == ebt_pkg::ST_SETUP);
    end
  end

  // Read data is taken as the read strobe rises
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rdata_r <= '0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (half_tick && state_r == ebt_pkg::ST_STROBE &&
          cnt_r == ebt_pkg::HALF_ONE) begin
        done_r <= 1'b1;
        if (!write_r && !internal_r) begin
          rdata_r <= DATA_IN;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Internal cycles show the latch strobe only
  always_comb begin
    ALE      = ale_r;
    ADDR_OUT = addr_r;
    CS_N     = 4'hF;
    RD_N     = 1'b1;
    WR_N     = 1'b1;
    DATA_OUT = '0;
    DATA_OE  = 1'b0;
    if (state_r != ebt_pkg::ST_IDLE && !internal_r) begin
      CS_N[space_r] = 1'b0;
      RD_N          = ~(strobe_r & ~write_r);
      WR_N          = ~(strobe_r & write_r);
      if (mux_r && state_r == ebt_pkg::ST_SETUP) begin
        DATA_OUT = addr_r[DW-1:0];
        DATA_OE  = 1'b1;
      end else if (write_r && state_r != ebt_pkg::ST_PAD) begin
        DATA_OUT = wdata_r;
        DATA_OE  = 1'b1;
      end
    end
  end

  assign REQ_DONE  = done_r;
  assign REQ_RDATA = rdata_r;

endmodule

// ---- ebt_bus_timing_assertions.sv ----
// Pin timing checker for the external bus cycle timing block
`timescale 1ns/1ps
module ebt_bus_timing_chk #(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input wire logic          CLOCK,
  input wire logic          NRST,
  input wire logic          REQ_READY,
  input wire logic          REQ_DONE,
  input wire logic [AW-1:0] ADDR_OUT,
  input wire logic [3:0]    CS_N,
  input wire logic          RD_N,
  input wire logic          WR_N,
  input wire logic          ALE,
  input wire logic          DATA_OE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  one_space_a: assert property ($onehot0(~CS_N))
    else $error("two spaces selected");
  strobe_sel_a: assert property (!(RD_N && WR_N) |-> CS_N != 4'hF)
    else $error("strobe without a space");
  rd_min_a: assert property ($fell(RD_N) |-> !RD_N [*3])
    else $error("read strobe too short");
  wr_min_a: assert property ($fell(WR_N) |-> !WR_N [*3])
    else $error("write strobe too short");
  done_rise_a: assert property ($rose(RD_N) || $rose(WR_N) |-> REQ_DONE)
    else $error("done not at strobe end");
  ale_lead_a: assert property ($fell(ALE) && CS_N != 4'hF
    |-> ##[1:8] (!RD_N || !WR_N)) else $error("strobe late after latch");
  ale_off_a: assert property (!(RD_N && WR_N) |-> !ALE)
    else $error("latch high in strobe");
  // Ready may only meet a strobe on its closing tick
  busy_ready_a: assert property (!(RD_N && WR_N) && REQ_READY
    |=> RD_N && WR_N) else $error("ready during strobe");
  addr_hold_a: assert property (!RD_N && !$past(RD_N)
    |-> $stable(ADDR_OUT)) else $error("address moved in strobe");
  wr_drive_a: assert property (!WR_N |-> DATA_OE)
    else $error("write data not driven");
endmodule

bind ebt_bus_timing ebt_bus_timing_chk #(.AW(AW), .DW(DW)) ebt_bus_timing_chk_i (
  .CLOCK(CLOCK), .NRST(NRST), .REQ_READY(REQ_READY), .REQ_DONE(REQ_DONE),
  .ADDR_OUT(ADDR_OUT), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ALE(ALE),
  .DATA_OE(DATA_OE));

// ---- ebt_ext_mem.sv ----
// External memory model on the far side of the bus pins
`timescale 1ns/1ps
module ebt_ext_mem (
  input  wire logic        clk,
  input  wire logic [3:0]  cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        ale,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] dout,
  output logic      [15:0] din,
  output logic      [15:0] wr_q,
  output logic      [15:0] lat_q
);
  logic [15:0] last_r = 16'h0000;
  logic        ale_r = 1'b0;
  // Released bus toggles so a late sample never matches by luck
  assign din = (cs_n != 4'hF && !rd_n) ? (addr[15:0] ^ 16'h5A5A) : ~last_r;
  always @(posedge clk) begin
    last_r <= din;
    ale_r <= ale;
    if (ale_r && !ale) begin
      lat_q <= dout;
    end
    if (!wr_n) begin
      wr_q <= dout;
    end
  end
endmodule

// ---- ebt_bus_timing_tb.sv ----
// Self-checking bench for the external bus cycle timing block
`timescale 1ns/1ps
module ebt_bus_timing_tb;
  logic        CLOCK = 1'b0;
  logic        NRST = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic        REQ_VALID = 1'b0;
  logic        REQ_WRITE = 1'b0;
  logic        REQ_INTERNAL = 1'b0;
  logic [1:0]  REQ_SPACE = 2'b00;
  logic [23:0] REQ_ADDR = 24'h00_0000;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, REQ_READY, REQ_DONE, RD_N, WR_N, ALE, DATA_OE;
  logic [15:0] REQ_RDATA, DATA_IN, DATA_OUT, wr_q, lat_q;
  logic [23:0] ADDR_OUT;
  logic [3:0]  CS_N;
  logic        perr;
  int          fail_count = 0;
  int          n_checks = 0;
  int          hk = 1;

  always #4 CLOCK = ~CLOCK;

  ebt_bus_timing ebt_bus_timing_i (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_INTERNAL(REQ_INTERNAL),
    .REQ_SPACE(REQ_SPACE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .REQ_READY(REQ_READY), .REQ_DONE(REQ_DONE), .REQ_RDATA(REQ_RDATA),
    .ADDR_OUT(ADDR_OUT), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ALE(ALE),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));

  ebt_ext_mem ebt_ext_mem_i (.clk(CLOCK), .cs_n(CS_N), .rd_n(RD_N),
    .wr_n(WR_N), .ale(ALE), .addr(ADDR_OUT), .dout(DATA_OUT), .din(DATA_IN),
    .wr_q(wr_q), .lat_q(lat_q));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  // One bus cycle, timed at the pins against the configured figures
  task automatic acc(logic [1:0] sp, logic wr, logic in, logic [10:0] cfg,
                     logic [3:0] cc);
    int m, d, su, wd, s, w, t, sc, wc, tc, ac;
    logic        dn;
    logic [31:0] q;
    logic [23:0] a;
    m = int'(cfg[9:8]) + 1;
    d = int'(cc[3:2]) + 1;
    hk = 1 << cc[1:0];
    su = wr ? int'(cfg[3:2]) : int'(cfg[7:6]);
    wd = wr ? int'(cfg[1:0]) : int'(cfg[5:4]);
    s = 2 * su * m + 2;
    w = 2 * (wd + 1) * m - 1;
    if (!wr && !cfg[10]) begin
      s = s - 1;
      w = w + 2;
    end
    t = (s + w + 2 * d - 1) / (2 * d) * 2 * d;
    a = 24'h00_1200 | {16'h0000, sp, wr, in, 4'h7};
    REQ_VALID <= 1'b1;
    REQ_WRITE <= wr;
    REQ_INTERNAL <= in;
    REQ_SPACE <= sp;
    REQ_ADDR <= a;
    REQ_WDATA <= ~a[15:0];
    do begin
      @(posedge CLOCK);
    end while (REQ_READY !== 1'b1);
    REQ_VALID <= 1'b0;
    sc = 0;
    wc = 0;
    tc = 0;
    ac = 0;
    dn = 1'b0;
    while (!(dn && CS_N === 4'hF && ALE === 1'b0)) begin
      @(negedge CLOCK);
      if (REQ_DONE === 1'b1) dn = 1'b1;
      if (CS_N !== 4'hF && RD_N === 1'b1 && WR_N === 1'b1 && !dn) sc++;
      if (RD_N === 1'b0 || WR_N === 1'b0) wc++;
      if (CS_N !== 4'hF) tc++;
      if (ALE === 1'b1) ac++;
    end
    @(posedge CLOCK);
    chk("setup", in ? 0 : s * hk, sc);
    chk("width", in ? 0 : w * hk, wc);
    chk("length", in ? 0 : t * hk, tc);
    chk("latch high", (s - 1) * hk, ac);
    if (!in) begin
      apb(1'b0, ebt_pkg::OFF_STATUS, 32'h0000_0000, q);
      chk("status", t, {25'h0, q[14:8]});
      if (wr) chk("wdata", {16'h0000, ~a[15:0]}, wr_q);
      else chk("rdata", a[15:0] ^ 16'h5A5A, REQ_RDATA);
      if (cfg[10]) chk("mux addr", a[15:0], lat_q);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    chk("idle pins", 32'h0000_00FC, {CS_N, RD_N, WR_N, ALE, DATA_OE});
    apb(1'b0, ebt_pkg::OFF_SPACE3_CFG, 32'h0000_0000, q);
    chk("cfg reset", 32'h0000_07FF, q);
    apb(1'b0, ebt_pkg::OFF_CLOCK_CTRL, 32'h0000_0000, q);
    chk("clk reset", 32'h0000_0005, q);
    apb(1'b1, 8'h18, 32'h0000_0001, q);
    chk("slverr", 32'h0000_0001, perr);
    apb(1'b0, 8'h18, 32'h0000_0000, q);
    chk("unmapped", 32'h0000_0000, q);
    acc(2'd3, 1'b0, 1'b0, 11'h7FF, 4'h5);
  endtask

  // Each space differs, so a wrong register choice shows in the timing
  task automatic t_sweep();
    logic [31:0] q;
    logic [10:0] c [4];
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 4; i++) begin
        c[i] = {1'(f), 2'(i), 2'(i), 2'(3 - i), 2'(i), 2'(3 - i)};
        apb(1'b1, 8'(4 * i), {21'h0, c[i]}, q);
      end
      for (int i = 0; i < 4; i++) begin
        // Base divider follows the space, so every divider code is run
        apb(1'b1, ebt_pkg::OFF_CLOCK_CTRL, {28'h0, 2'(i), 2'(i)}, q);
        acc(2'(i), 1'b0, 1'b0, c[i], {2'(i), 2'(i)});
        acc(2'(i), 1'b1, 1'b0, c[i], {2'(i), 2'(i)});
        if (f == 1) acc(2'(i), 1'b0, 1'b1, c[i], {2'(i), 2'(i)});
      end
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    t_reset();
    t_sweep();
    stop_test();
  end

  initial begin
    repeat (30000) @(posedge CLOCK);
    fail_count++;
    stop_test();
  end
endmodule
